// [hdl/ssp_pkg.sv]
// package for the strap sampling and status pin block
package ssp_pkg;
    // strap sampling: synchroniser stages the pins pass before the latch point
    localparam int unsigned SYNC_STAGES = 2;
    // reset values of the latched straps (pin pull levels)
    localparam logic RST_GANGED = 1'h0; // ganged-select pin pulled down
    localparam logic RST_AUTO_N = 1'h1; // automatic-charge pin pulled up
    localparam logic RST_BUS_MODE = 1'h1; // bus-mode pin pulled up
    localparam logic RST_PWR_MGMT_N = 1'h0; // power management pin pulled down
    // config constants: slave address bit, charging-excluded port, port count
    localparam int unsigned SLAVE_ADDR_BIT = 2;
    localparam int unsigned CHG_EXCLUDED_PORT = 1;
    localparam int unsigned NUM_PORTS = 4;

    // latched strap values
    typedef struct packed {
        logic ganged;          // 1 ganged, 0 individual
        logic auto_charge_n;   // 0 automatic mode enabled
        logic bus_mode;        // 1 i2c master, 0 smbus slave
        logic power_mgmt_n;    // 0 power switching enabled
    } ssp_straps_t;

    // drive side of one dual-use pin
    typedef struct packed {
        logic o;
        logic oe;
    } ssp_pin_drv_t;

    typedef enum logic [1:0] {
        SSP_RESET = 2'b00,
        SSP_SAMPLE = 2'b01,
        SSP_RUN = 2'b10
    } ssp_state_t;
endpackage : ssp_pkg

// [hdl/ssp_strap_status.sv]
// strap latch and post-reset status drive for the ganged and auto-charge pins
`timescale 1ns/1ps
module ssp_strap_status #(
    parameter int NUM_PORTS = ssp_pkg::NUM_PORTS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // dual-use pins, input side
    input wire logic ganged_pin_i,
    input wire logic auto_charge_strap_n_i,
    // strap-only pins
    input wire logic bus_mode_strap,
    input wire logic power_mgmt_strap_n,
    // status from the hub core
    input wire logic upstream_highspeed_connected,
    input wire logic upstream_highspeed_suspended,
    input wire logic hs_status_enable,
    // per-port charging enables from configuration
    input wire logic [NUM_PORTS-1:0] charge_port_enable,
    // dual-use pins, drive side
    output logic ganged_pin_o,
    output logic ganged_pin_oe,
    output logic auto_charge_pin_o,
    output logic auto_charge_pin_oe,
    // latched configuration outputs
    output logic ganged_power,
    output logic individual_power,
    output logic power_switching_en,
    output logic i2c_master_mode,
    output logic smbus_slave_mode,
    output logic slave_addr_bit2,
    output logic auto_charge_disable_bit,
    output logic auto_charge_mode,
    output logic [NUM_PORTS-1:0] charging_downstream_port_mode,
    output logic straps_valid
);
    // strap pins travel as one word through the synchroniser
    localparam int PIN_COUNT = $bits(ssp_pkg::ssp_straps_t);

    // synced pins and latch state
    logic [PIN_COUNT-1:0] pins_sync;
    ssp_pkg::ssp_straps_t straps;
    ssp_pkg::ssp_straps_t next_straps;
    ssp_pkg::ssp_state_t state;
    ssp_pkg::ssp_state_t next_state;

    // status pin drive
    ssp_pkg::ssp_pin_drv_t drv_gang;
    ssp_pkg::ssp_pin_drv_t drv_auto;
    ssp_pkg::ssp_pin_drv_t next_drv_gang;
    ssp_pkg::ssp_pin_drv_t next_drv_auto;

    // next values of the decoded outputs
    logic next_ganged_power;
    logic next_individual_power;
    logic next_power_switching_en;
    logic next_i2c_master_mode;
    logic next_smbus_slave_mode;
    logic next_slave_addr_bit2;
    logic next_auto_charge_disable_bit;
    logic next_auto_charge_mode;
    logic [NUM_PORTS-1:0] next_chg_port_mode;
    logic next_straps_valid;
    // charging allowed per port by the strap, before the enables
    logic [NUM_PORTS-1:0] port_keep;

    // every pin passes two flops before the latch reads it
    ssp_sync #(
        .WIDTH(PIN_COUNT)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({ganged_pin_i, auto_charge_strap_n_i, bus_mode_strap,
                   power_mgmt_strap_n}),
        .sync_out(pins_sync)
    );

    // strap latch: one idle state after release, then a single sample
    // with two sync flops the sample still takes the pin level of the last cycle under reset
    always_comb begin
        next_state = state;
        next_straps = straps;
        unique case (state)
            ssp_pkg::SSP_RESET: begin
                next_state = ssp_pkg::SSP_SAMPLE;
            end
            ssp_pkg::SSP_SAMPLE: begin
                // pins still inputs here, so the synced level is the strap
                next_straps.ganged = pins_sync[3];
                next_straps.auto_charge_n = pins_sync[2];
                next_straps.bus_mode = pins_sync[1];
                next_straps.power_mgmt_n = pins_sync[0];
                next_state = ssp_pkg::SSP_RUN;
            end
            ssp_pkg::SSP_RUN: begin
                // straps never move again until the next reset
                next_state = ssp_pkg::SSP_RUN;
            end
            default: begin
                next_state = ssp_pkg::SSP_RESET;
            end
        endcase
        // reset wins over the state walk and restores the pull levels
        if (!rst_b) begin
            next_state = ssp_pkg::SSP_RESET;
            next_straps = '{ganged: ssp_pkg::RST_GANGED,
                            auto_charge_n: ssp_pkg::RST_AUTO_N,
                            bus_mode: ssp_pkg::RST_BUS_MODE,
                            power_mgmt_n: ssp_pkg::RST_PWR_MGMT_N};
        end
    end

    always_ff @(posedge clk) begin
        state <= next_state;
        straps <= next_straps;
    end

    // per-port keep mask: port 1 sits at index 0 and is barred only in automatic mode
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        if (p == ssp_pkg::CHG_EXCLUDED_PORT - 1) begin : g_barred
            assign port_keep[p] = straps.auto_charge_n;
        end else begin : g_free
            assign port_keep[p] = 1'h1;
        end
    end

    // power control decode; reset and the pre-latch window hold all low
    // gang choice matters only with switching enabled
    always_comb begin
        next_straps_valid = rst_b && (state == ssp_pkg::SSP_RUN);
        next_power_switching_en = next_straps_valid && !straps.power_mgmt_n;
        next_ganged_power = next_power_switching_en && straps.ganged;
        next_individual_power = next_power_switching_en && !straps.ganged;
    end

    // power control registers
    always_ff @(posedge clk) begin
        straps_valid <= next_straps_valid;
        power_switching_en <= next_power_switching_en;
        ganged_power <= next_ganged_power;
        individual_power <= next_individual_power;
    end

    // bus mode decode
    // address bit only meaningful in smbus mode, else held low
    always_comb begin
        next_i2c_master_mode = next_straps_valid && straps.bus_mode;
        next_smbus_slave_mode = next_straps_valid && !straps.bus_mode;
        next_slave_addr_bit2 = next_smbus_slave_mode && straps.ganged;
    end

    // bus mode registers
    always_ff @(posedge clk) begin
        i2c_master_mode <= next_i2c_master_mode;
        smbus_slave_mode <= next_smbus_slave_mode;
        slave_addr_bit2 <= next_slave_addr_bit2;
    end

    // charging decode
    // relies on board strapping; gang does not block charging here
    always_comb begin
        next_auto_charge_disable_bit = next_straps_valid && straps.auto_charge_n;
        next_auto_charge_mode = next_straps_valid && !straps.auto_charge_n;
        next_chg_port_mode = charge_port_enable & port_keep;
        // the core must never see charging offered before the straps are known
        if (!next_straps_valid) begin
            next_chg_port_mode = '0;
        end
    end

    // charging registers
    always_ff @(posedge clk) begin
        auto_charge_disable_bit <= next_auto_charge_disable_bit;
        auto_charge_mode <= next_auto_charge_mode;
        charging_downstream_port_mode <= next_chg_port_mode;
    end

    // one status pin: input until latched, then driven only while enabled
    function automatic ssp_pkg::ssp_pin_drv_t status_drive(input logic valid,
                                                           input logic enable,
                                                           input logic status);
        ssp_pkg::ssp_pin_drv_t drv;
        drv.oe = valid && enable;
        drv.o = drv.oe && status;
        return drv;
    endfunction : status_drive

    // status drive; both pins share the enable and the latch gate
    // a low while enabled is a driven low, never a released pin
    always_comb begin
        next_drv_gang = status_drive(next_straps_valid, hs_status_enable,
                                     upstream_highspeed_connected);
        next_drv_auto = status_drive(next_straps_valid, hs_status_enable,
                                     upstream_highspeed_suspended);
    end

    // status pin registers
    always_ff @(posedge clk) begin
        drv_gang <= next_drv_gang;
        drv_auto <= next_drv_auto;
    end

    // pin outputs straight from flops
    assign ganged_pin_o = drv_gang.o;
    assign ganged_pin_oe = drv_gang.oe;
    assign auto_charge_pin_o = drv_auto.o;
    assign auto_charge_pin_oe = drv_auto.oe;
    // factory test pin is not an input of this block
endmodule : ssp_strap_status

// [hdl/ssp_sync.sv]
// two-stage synchroniser for strap and status pin inputs
`timescale 1ns/1ps
module ssp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // async in, synced out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    // first stage feeds only the second stage
    always_comb begin
        next_meta = async_in;
        next_sync_out = meta;
    end

    // no reset value: pins are sampled from the first edge
    always_ff @(posedge clk) begin
        meta <= next_meta;
        sync_out <= next_sync_out;
    end
endmodule : ssp_sync

// [testbench/ssp_asserts.sv]
// checker for the strap latch and status pin block
`timescale 1ns/1ps
module ssp_chk #(
    parameter int NUM_PORTS = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // status inputs
    input wire logic upstream_highspeed_connected,
    input wire logic upstream_highspeed_suspended,
    input wire logic hs_status_enable,
    // pin drive
    input wire logic ganged_pin_o,
    input wire logic ganged_pin_oe,
    input wire logic auto_charge_pin_o,
    input wire logic auto_charge_pin_oe,
    // latched configuration
    input wire logic ganged_power,
    input wire logic individual_power,
    input wire logic power_switching_en,
    input wire logic i2c_master_mode,
    input wire logic smbus_slave_mode,
    input wire logic slave_addr_bit2,
    input wire logic auto_charge_disable_bit,
    input wire logic auto_charge_mode,
    input wire logic [NUM_PORTS-1:0] charging_downstream_port_mode,
    input wire logic straps_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // two quiet cycles after release before the latch can show
    sequence s_quiet; !straps_valid ##1 !straps_valid; endsequence
    property p_latch; $rose(rst_b) |-> s_quiet ##[1:4] straps_valid; endproperty
    a_latch: assert property (p_latch) else $error("straps not latched in time");
    property p_hold; straps_valid && $past(straps_valid) |->
        $stable({ganged_power, i2c_master_mode, slave_addr_bit2, auto_charge_mode}); endproperty
    a_hold: assert property (p_hold) else $error("strap value moved");
    property p_pwr; straps_valid |-> {ganged_power, individual_power} != 2'h3 &&
        (ganged_power | individual_power) == power_switching_en; endproperty
    a_pwr: assert property (p_pwr) else $error("power control decode");
    property p_bus; straps_valid |-> i2c_master_mode != smbus_slave_mode &&
        !(i2c_master_mode && slave_addr_bit2); endproperty
    a_bus: assert property (p_bus) else $error("bus mode decode");
    property p_auto; straps_valid |-> auto_charge_mode != auto_charge_disable_bit; endproperty
    a_auto: assert property (p_auto) else $error("auto disable bit");
    property p_port1_chg; auto_charge_mode |-> !charging_downstream_port_mode[0]; endproperty
    a_port1_chg: assert property (p_port1_chg) else $error("port 1 charging mode in auto mode");
    property p_early; !straps_valid |-> !ganged_pin_oe && !auto_charge_pin_oe; endproperty
    a_early: assert property (p_early) else $error("pin driven before latch");
    property p_conn_drive; straps_valid && $past(straps_valid) |-> {ganged_pin_oe, ganged_pin_o} ==
        {$past(hs_status_enable), $past(hs_status_enable & upstream_highspeed_connected)};
    endproperty
    a_conn_drive: assert property (p_conn_drive) else $error("connect status drive");
    property p_hs_susp; straps_valid && $past(straps_valid) |->
        {auto_charge_pin_oe, auto_charge_pin_o} == {$past(hs_status_enable),
        $past(hs_status_enable & upstream_highspeed_suspended)}; endproperty
    a_hs_susp: assert property (p_hs_susp) else $error("suspend status drive");
endmodule : ssp_chk
bind ssp_strap_status ssp_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.clk, .rst_b,
    .upstream_highspeed_connected, .upstream_highspeed_suspended, .hs_status_enable,
    .ganged_pin_o, .ganged_pin_oe, .auto_charge_pin_o, .auto_charge_pin_oe, .ganged_power,
    .individual_power, .power_switching_en, .i2c_master_mode, .smbus_slave_mode,
    .slave_addr_bit2, .auto_charge_disable_bit, .auto_charge_mode,
    .charging_downstream_port_mode, .straps_valid);

// [testbench/ssp_board.sv]
// board model: strap resistors on the two dual-use pins
`timescale 1ns/1ps
module ssp_board (
    // strap resistor choices
    input wire logic gang_strap,
    input wire logic auto_strap_n,
    // device pin drive
    input wire logic g_o,
    input wire logic g_oe,
    input wire logic a_o,
    input wire logic a_oe,
    // resolved pin levels
    output logic gang_pin,
    output logic auto_pin
);
    // resistors are weak, device drive wins
    assign gang_pin = g_oe ? g_o : gang_strap;
    assign auto_pin = a_oe ? a_o : auto_strap_n;
endmodule : ssp_board

// [testbench/tb.sv]
// self-checking bench for the strap latch and status pin block
`timescale 1ns/1ps
module tb;
    logic clk, rst_b, gs, an, bm, pm, hc, hsu, hen, gp, ap, go, goe, ao, aoe;
    logic gpw, ipw, psw, i2c, smb, sa2, adb, acm, sv;
    logic [3:0] cpe, cpm;
    int error_cnt, n_compared, k;
    ssp_board board (.gang_strap(gs), .auto_strap_n(an), .g_o(go), .g_oe(goe), .a_o(ao),
        .a_oe(aoe), .gang_pin(gp), .auto_pin(ap));
    ssp_strap_status DUT (.clk(clk), .rst_b(rst_b), .ganged_pin_i(gp),
        .auto_charge_strap_n_i(ap), .bus_mode_strap(bm), .power_mgmt_strap_n(pm),
        .upstream_highspeed_connected(hc), .upstream_highspeed_suspended(hsu),
        .hs_status_enable(hen), .charge_port_enable(cpe), .ganged_pin_o(go),
        .ganged_pin_oe(goe), .auto_charge_pin_o(ao), .auto_charge_pin_oe(aoe),
        .ganged_power(gpw), .individual_power(ipw), .power_switching_en(psw),
        .i2c_master_mode(i2c), .smbus_slave_mode(smb), .slave_addr_bit2(sa2),
        .auto_charge_disable_bit(adb), .auto_charge_mode(acm),
        .charging_downstream_port_mode(cpm), .straps_valid(sv));
    // free-running 50 mhz clock
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    task chk(input logic [3:0] got, input logic [3:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask : chk
    task finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // reset with given straps; pins must not be driven until the latch shows
    task do_reset(input logic [3:0] s);
        int i;
        {gs, an, bm, pm} <= s;
        rst_b <= 1'h0;
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        for (i = 0; i < 10 && sv !== 1'h1; i++) begin
            @(negedge clk);
            if (sv !== 1'h1) chk({goe, aoe}, 4'h0, "early drive");
        end
        if (sv !== 1'h1) begin
            error_cnt++;
            finish_test();
        end
    endtask : do_reset
    // all sixteen strap sets, then the status drive table
    initial begin
        rst_b = 1'h0;
        {gs, an, bm, pm, hc, hsu, hen} = 7'h7f;
        cpe = 4'h0;
        repeat (6) @(posedge clk);
        for (k = 0; k < 16; k++) begin
            // each test starts on a rising edge so every input moves there
            @(posedge clk);
            cpe <= k[3] ? 4'h0 : 4'hf; // charging only with individual power strapped
            do_reset(k[3:0]);
            @(posedge clk);
            {gs, an, bm, pm} <= ~k[3:0]; // late pin changes must be ignored
            repeat (4) @(negedge clk);
            chk({1'h0, gpw, ipw, psw}, {1'h0, k[3] & ~k[0], ~k[3] & ~k[0], ~k[0]}, "pwr");
            chk({i2c, smb, sa2, 1'h0}, {k[1], ~k[1], k[3] & ~k[1], 1'h0}, "bus");
            chk({adb, acm, 2'h0}, {k[2], ~k[2], 2'h0}, "auto");
            chk(cpm, cpe & {3'h7, k[2]}, "port mode");
            $display("strap set %0d done", k);
        end
        for (k = 0; k < 8; k++) begin
            @(posedge clk);
            {hen, hc, hsu} <= k[2:0];
            repeat (3) @(negedge clk);
            chk({goe, go, aoe, ao}, {k[2], k[2] & k[1], k[2], k[2] & k[0]}, "status");
        end
        $display("status drive test done");
        finish_test();
    end
endmodule : tb
